// *** logic/stv_top.sv ***
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "stv_params.svh"
// Summary of operation
// - low trip 110..155 C by code, reset 2
// - high trip offset 15..60 C, reset 0
// - poll interval 4/8/16/32 ms, reset 8
// - bits 7/6 show high/low trip flags
// - hard switch mode ignores low flag
// - hard mode, high flag: volume zero
// - hard mode, no high: volume ceiling
// - hard mode still mutes then powers down
// - bit 6 selects hard mode, steps ignored
// - bit 7 allows powerdown when muted, reset 1
// - raise once per 1/2/4/8 polls
// - raise step 0.75 to 6 dB
// - lower step 3 to 24 dB, reset 6
// - status bit 7 shows thermal powerdown
// - status shows limited volume value
// - control bit 1 enables thermal protection
// - control bit 0 enables zero-cross timeout
// - short disables output, retries after delay
// - both flags clear: raise, spaced by ratio
// - low only: hold volume
// - high: lower every poll down to minimum
// - high at minimum: mute, then power down
module stv_top #(
  parameter int unsigned POLL_BASE_CYC =
    `STV_POLL_BASE_US * (`STV_MCLK_HZ / 1000000),
  parameter int unsigned SHORT_RETRY_CYC =
    `STV_SHORT_RETRY_US * (`STV_MCLK_HZ / 1000000),
  parameter int unsigned ZC_TIMEOUT_CYC =
    `STV_ZC_TIMEOUT_US * (`STV_MCLK_HZ / 1000000)
) (
  input  wire logic                 mclk,             // core clock
  input  wire logic                 rst,              // sync reset
  input  wire stv_pkg::stv_apb_req_s apb_req,         // apb request
  output stv_pkg::stv_apb_rsp_s      apb_rsp,         // apb answer
  input  wire logic                 high_overheat_in, // sensor high trip
  input  wire logic                 low_overheat_in,  // sensor low trip
  input  wire logic [6:0]           vol_left,         // left setting
  input  wire logic [6:0]           vol_right,        // right setting
  input  wire logic                 zero_cross,       // zero crossing
  input  wire logic                 short_det,        // btl short seen
  output logic [6:0]                spk_volume,       // applied volume
  output logic                      spk_mute,         // thermal mute
  output logic                      spk_powerdown,    // thermal pwd
  output logic                      btl_enable,       // btl stage on
  output logic [7:0]                low_trip_degc,    // low trip temp
  output logic [7:0]                high_trip_degc    // high trip temp
);
  import stv_pkg::*;

  stv_state_s st_r;
  stv_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers

  logic [6:0] ceil_vol;
  logic       access;
  logic       commit;
  logic [9:0] idx;
  logic       hit;
  logic       tick;
  logic [2:0] ratio_lim;
  logic [6:0] inc_step;
  logic [6:0] dec_step;
  logic [7:0] raised;
  logic [1:0] poll_sel;
  logic [7:0] lo_trip;
  logic [7:0] split_deg;
  logic [19:0] poll_reload;
  logic [7:0] rd_byte;

  always_comb begin
    ceil_vol  = (vol_left > vol_right) ? vol_left : vol_right;
    access    = apb_req.psel & apb_req.penable;
    commit    = access & st_r.rsp.pready & apb_req.pwrite &
                ~st_r.rsp.pslverr;
    idx       = apb_req.paddr[11:2];
    hit       = (idx == `STV_IDX_CTL) || (idx == `STV_IDX_THERM_TS) ||
                (idx == `STV_IDX_SPKR_CTL) ||
                (idx == `STV_IDX_SPKR_STAT);
    tick      = (st_r.poll_cnt == 20'h00000);
    poll_sel  = st_r.ts[`STV_TS_POLL_LSB +: 2];
    raised    = {1'b0, st_r.vol} + {1'b0, inc_step};
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decodes, spelled out so every code is easy to audit

  // low trip point in degrees C
  always_comb begin
    case (st_r.ts[`STV_TS_SHIFT_LSB +: 2])
      2'h0:    lo_trip = 8'h6E;
      2'h1:    lo_trip = 8'h7D;
      2'h2:    lo_trip = 8'h8C;
      2'h3:    lo_trip = 8'h9B;
      default: lo_trip = 8'h8C;
    endcase
  end

  // distance of the high trip above the low one
  always_comb begin
    case (st_r.ts[`STV_TS_SPLIT_LSB +: 2])
      2'h0:    split_deg = 8'h0F;
      2'h1:    split_deg = 8'h1E;
      2'h2:    split_deg = 8'h2D;
      2'h3:    split_deg = 8'h3C;
      default: split_deg = 8'h0F;
    endcase
  end

  // poll reload; a new interval only starts at the next tick
  always_comb begin
    case (poll_sel)
      2'h0:    poll_reload = 20'(POLL_BASE_CYC - 1);
      2'h1:    poll_reload = 20'(POLL_BASE_CYC * 2 - 1);
      2'h2:    poll_reload = 20'(POLL_BASE_CYC * 4 - 1);
      2'h3:    poll_reload = 20'(POLL_BASE_CYC * 8 - 1);
      default: poll_reload = 20'(POLL_BASE_CYC * 2 - 1);
    endcase
  end

  // polls to skip between raises
  always_comb begin
    case (st_r.spkr[`STV_SPKR_RATIO_LSB +: 2])
      2'h0:    ratio_lim = 3'h0;
      2'h1:    ratio_lim = 3'h1;
      2'h2:    ratio_lim = 3'h3;
      2'h3:    ratio_lim = 3'h7;
      default: ratio_lim = 3'h0;
    endcase
  end

  // raise step in 0.75 dB codes
  always_comb begin
    case (st_r.spkr[`STV_SPKR_INC_LSB +: 2])
      2'h0:    inc_step = 7'h01;
      2'h1:    inc_step = 7'h02;
      2'h2:    inc_step = 7'h04;
      2'h3:    inc_step = 7'h08;
      default: inc_step = 7'h01;
    endcase
  end

  // lower step in 0.75 dB codes
  always_comb begin
    case (st_r.spkr[`STV_SPKR_DEC_LSB +: 2])
      2'h0:    dec_step = 7'h04;
      2'h1:    dec_step = 7'h08;
      2'h2:    dec_step = 7'h10;
      2'h3:    dec_step = 7'h20;
      default: dec_step = 7'h08;
    endcase
  end

  // read-back byte; unmapped offsets read zero
  always_comb begin
    case (idx)
      `STV_IDX_CTL:       rd_byte = st_r.ctl;
      `STV_IDX_THERM_TS:  rd_byte = {st_r.hi, st_r.lo, st_r.ts};
      `STV_IDX_SPKR_CTL:  rd_byte = st_r.spkr;
      `STV_IDX_SPKR_STAT: rd_byte = {st_r.pwd, st_r.vol};
      default:            rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;

    // apb slave: one wait state, answer registered
    st_nxt.rsp.pready  = access & ~st_r.rsp.pready;
    st_nxt.rsp.pslverr = access & ~st_r.rsp.pready & ~hit;
    st_nxt.rsp.prdata  = 32'h00000000;
    if (access && !st_r.rsp.pready && !apb_req.pwrite) begin
      st_nxt.rsp.prdata[7:0] = rd_byte;
    end
    if (commit) begin
      case (idx)
        `STV_IDX_CTL:      st_nxt.ctl  = apb_req.pwdata[7:0];
        `STV_IDX_THERM_TS: st_nxt.ts   = apb_req.pwdata[5:0];
        `STV_IDX_SPKR_CTL: st_nxt.spkr = apb_req.pwdata[7:0];
        default:           st_nxt.ctl  = st_r.ctl;
      endcase
    end

    // trip points for the sensor
    // both from one decode, so the pair never shows a stale split
    st_nxt.lo_degc = lo_trip;
    st_nxt.hi_degc = lo_trip + split_deg;

    // flags sampled every cycle, acted on only at poll ticks
    st_nxt.hi = high_overheat_in;
    st_nxt.lo = low_overheat_in;

    // poll counter free-runs; interval change takes effect at next tick
    if (tick) begin
      st_nxt.poll_cnt = poll_reload;
    end else begin
      st_nxt.poll_cnt = st_r.poll_cnt - 20'h00001;
    end

    if (!st_r.ctl[`STV_CTL_THERMAL_PROTECT_ENABLE]) begin
      // protection off: follow the settings, never mute
      st_nxt.vol     = ceil_vol;
      st_nxt.mute    = 1'b0;
      st_nxt.pwd     = 1'b0;
      st_nxt.inc_cnt = 3'h0;
    end else if (tick) begin
      if (st_r.hi) begin
        // escalate only once volume already sits at the minimum
        if (st_r.vol == 7'h00) begin
          if (!st_r.mute) begin
            st_nxt.mute = 1'b1;
          end else if (st_r.spkr[`STV_SPKR_PWDEN]) begin
            st_nxt.pwd = 1'b1;
          end
        end
      end else begin
        st_nxt.mute = 1'b0;
        st_nxt.pwd  = 1'b0;
      end
      if (st_r.spkr[`STV_SPKR_HARD]) begin
        // steps and low flag ignored here
        st_nxt.inc_cnt = 3'h0;
        if (st_r.hi) begin
          st_nxt.vol = 7'h00;
        end else begin
          st_nxt.vol = ceil_vol;
        end
      end else if (st_r.hi) begin
        st_nxt.inc_cnt = 3'h0;
        if (st_r.vol > dec_step) begin
          st_nxt.vol = st_r.vol - dec_step;
        end else begin
          st_nxt.vol = 7'h00;
        end
      end else if (st_r.lo) begin
        st_nxt.vol = st_r.vol;
      end else if (st_r.inc_cnt >= ratio_lim) begin
        st_nxt.inc_cnt = 3'h0;
        if (raised > {1'b0, ceil_vol}) begin
          st_nxt.vol = ceil_vol;
        end else begin
          st_nxt.vol = raised[6:0];
        end
      end else begin
        st_nxt.inc_cnt = st_r.inc_cnt + 3'h1;
      end
    end

    // settings lowered under us: never exceed the ceiling
    if (st_nxt.vol > ceil_vol) begin
      st_nxt.vol = ceil_vol;
    end

    // apply at zero crossing; timeout avoids a stuck level on silence
    if (st_r.vol_out == st_r.vol) begin
      st_nxt.zc_cnt = 20'(ZC_TIMEOUT_CYC - 1);
    end else if (zero_cross ||
                 (st_r.ctl[`STV_CTL_ZERO_CROSS_TIMEOUT_ENABLE] && st_r.zc_cnt == 20'h00000))
    begin
      st_nxt.vol_out = st_r.vol;
      st_nxt.zc_cnt  = 20'(ZC_TIMEOUT_CYC - 1);
    end else if (st_r.zc_cnt != 20'h00000) begin
      st_nxt.zc_cnt = st_r.zc_cnt - 20'h00001;
    end

    // short protection: off for a retry delay, then try again
    case (st_r.sc)
      STV_SC_ON: begin
        if (short_det) begin
          st_nxt.sc     = STV_SC_OFF;
          st_nxt.sc_cnt = 20'(SHORT_RETRY_CYC - 1);
        end
      end
      STV_SC_OFF: begin
        if (st_r.sc_cnt == 20'h00000) begin
          st_nxt.sc = STV_SC_ON;
        end else begin
          st_nxt.sc_cnt = st_r.sc_cnt - 20'h00001;
        end
      end
      default: st_nxt.sc = STV_SC_OFF;
    endcase
    st_nxt.btl_en = (st_nxt.sc == STV_SC_ON) & ~st_nxt.pwd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r          <= '0;
      st_r.ctl      <= `STV_CTL_RST;
      st_r.ts       <= `STV_TS_RST;
      st_r.spkr     <= `STV_SPKR_RST;
      st_r.sc       <= STV_SC_ON;
      st_r.btl_en   <= 1'b1;
      st_r.lo_degc  <= `STV_LO_DEGC_RST;
      st_r.hi_degc  <= `STV_HI_DEGC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp        = st_r.rsp;
  assign spk_volume     = st_r.vol_out;
  assign spk_mute       = st_r.mute;
  assign spk_powerdown  = st_r.pwd;
  assign btl_enable     = st_r.btl_en;
  assign low_trip_degc  = st_r.lo_degc;
  assign high_trip_degc = st_r.hi_degc;

endmodule

// *** logic/stv_params.svh ***
`ifndef STV_PARAMS_SVH
`define STV_PARAMS_SVH

// register indices; byte address is four times the index
`define STV_IDX_CTL        10'h01C
`define STV_IDX_THERM_TS   10'h01D
`define STV_IDX_SPKR_CTL   10'h01E
`define STV_IDX_SPKR_STAT  10'h088

// reset values
`define STV_CTL_RST        8'h00
`define STV_TS_RST         6'h09
`define STV_SPKR_RST       8'h81
`define STV_LO_DEGC_RST    8'h8C
`define STV_HI_DEGC_RST    8'h9B

// field positions
`define STV_CTL_THERMAL_PROTECT_ENABLE      1
`define STV_CTL_ZERO_CROSS_TIMEOUT_ENABLE       0
`define STV_SPKR_PWDEN     7
`define STV_SPKR_HARD      6
`define STV_SPKR_RATIO_LSB 4
`define STV_SPKR_INC_LSB   2
`define STV_SPKR_DEC_LSB   0
`define STV_TS_SPLIT_LSB   4
`define STV_TS_SHIFT_LSB   2
`define STV_TS_POLL_LSB    0

// trip temperatures in degrees C
`define STV_LOW_BASE_DEGC  8'h6E
`define STV_TRIP_STEP_DEGC 8'h0F

// volume codes are 0.75 dB each
`define STV_INC_BASE_CODE  7'h01
`define STV_DEC_BASE_CODE  7'h04

// timing
`define STV_MCLK_HZ        10000000
`define STV_POLL_BASE_US   4000
`define STV_SHORT_RETRY_US 1000
`define STV_ZC_TIMEOUT_US  2000

`endif

// *** logic/stv_pkg.sv ***
package stv_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } stv_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } stv_apb_rsp_s;

  typedef enum logic {STV_SC_ON, STV_SC_OFF} stv_short_e;

  typedef struct packed {
    stv_apb_rsp_s rsp;
    logic [7:0]   ctl;
    logic [5:0]   ts;
    logic [7:0]   spkr;
    logic         hi;
    logic         lo;
    logic [19:0]  poll_cnt;
    logic [2:0]   inc_cnt;
    logic [6:0]   vol;
    logic         mute;
    logic         pwd;
    logic [6:0]   vol_out;
    logic [19:0]  zc_cnt;
    stv_short_e   sc;
    logic [19:0]  sc_cnt;
    logic         btl_en;
    logic [7:0]   lo_degc;
    logic [7:0]   hi_degc;
  } stv_state_s;

endpackage

// *** verif/stv_top_props.sv ***
`timescale 1ns/100ps
module stv_top_props (
  input wire logic                  mclk,          // core clock
  input wire logic                  rst,           // sync reset
  input wire stv_pkg::stv_apb_req_s apb_req,       // apb request
  input wire stv_pkg::stv_apb_rsp_s apb_rsp,       // apb answer
  input wire logic                  short_det,     // short seen
  input wire logic                  spk_mute,      // thermal mute
  input wire logic                  spk_powerdown, // thermal pwd
  input wire logic                  btl_enable,    // btl stage on
  input wire logic [7:0]            low_trip_degc, // low trip
  input wire logic [7:0]            high_trip_degc // high trip
);
  import stv_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
////////////////////////////////////////////////////////////////////////
  sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
  sequence s_wait; apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  property p_rdy; s_setup ##1 s_wait |=> apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_idle;
    !apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("answer outside pready");
  property p_low; low_trip_degc inside {8'h6E, 8'h7D, 8'h8C, 8'h9B};
  endproperty
  a_low: assert property (p_low) else $error("low trip off");
  // judge only a settled pair, not the edge of a reconfiguration
  property p_split; $stable(low_trip_degc)[*4] |->
    8'(high_trip_degc - low_trip_degc) inside {8'h0F, 8'h1E, 8'h2D, 8'h3C};
  endproperty
  a_split: assert property (p_split) else $error("split off");
  property p_short; short_det && btl_enable |=> !btl_enable; endproperty
  a_short: assert property (p_short) else $error("short kept");
  property p_pd; $rose(spk_powerdown) |-> spk_mute && $past(spk_mute);
  endproperty
  a_pd: assert property (p_pd) else $error("pwd before mute");
  property p_pd_btl; $rose(spk_powerdown) |-> ##[0:1] !btl_enable;
  endproperty
  a_pd_btl: assert property (p_pd_btl) else $error("btl on");
  property p_unmute; $fell(spk_mute) |-> !spk_powerdown; endproperty
  a_unmute: assert property (p_unmute) else $error("pwd kept");
endmodule

// *** verif/stv_heat_model.sv ***
`timescale 1ns/100ps
module stv_heat_model (
  input  wire logic       mclk,            // core clock
  input  wire logic [1:0] heat_cmd,        // 3 hot, 1 warm, 0 cool
  output logic            hi_flag  = 1'b0, // high trip
  output logic            lo_flag  = 1'b0, // low trip
  output logic            zc_pulse = 1'b0  // audio zero cross
);
  logic [2:0] zc_cnt_r = 3'h0;
  // high trip point sits above low, so hot sets both
  always @(posedge mclk) begin
    zc_cnt_r <= zc_cnt_r + 3'h1;
    hi_flag  <= heat_cmd[1];
    lo_flag  <= |heat_cmd;
    zc_pulse <= (zc_cnt_r == 3'h7);
  end
endmodule

// *** verif/stv_top_tb.sv ***
`timescale 1ns/100ps
module stv_top_tb;
  import stv_pkg::*;
  localparam logic R = 1'b0, W = 1'b1;
  localparam logic [11:0] A_CTL = 12'h070, A_TS = 12'h074;
  localparam logic [11:0] A_SPK = 12'h078, A_ST = 12'h220;
  logic         mclk = 1'b0, rst = 1'b1, shrt = 1'b0;
  stv_apb_req_s req  = '0;
  stv_apb_rsp_s rsp;
  logic [1:0]   heat = 2'h0;
  logic [6:0]   vl = 7'h00, vr = 7'h00, vol, cv;
  logic         hi, lo, zc, mute, pwd, btl;
  logic [7:0]   ltrip, htrip;
  logic [32:0]  expq[$];
  int           n_errors = 0, num_checks = 0, cyc = 0;
  stv_top #(.POLL_BASE_CYC(16), .SHORT_RETRY_CYC(4), .ZC_TIMEOUT_CYC(8))
    stv_top_i (.mclk(mclk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .high_overheat_in(hi), .low_overheat_in(lo), .vol_left(vl),
    .vol_right(vr), .zero_cross(zc), .short_det(shrt), .spk_volume(vol),
    .spk_mute(mute), .spk_powerdown(pwd), .btl_enable(btl),
    .low_trip_degc(ltrip), .high_trip_degc(htrip));
  stv_heat_model stv_heat_model_i (.mclk(mclk), .heat_cmd(heat),
    .hi_flag(hi), .lo_flag(lo), .zc_pulse(zc));
  initial forever #50 mclk = ~mclk;
////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // reads note {pslverr, prdata}; idle edge after keeps req single-driven
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [7:0] wd, input logic [32:0] ex);
    int t;
    t = 0;
    if (!wr) expq.push_back(ex);
    req <= '{1'b1, 1'b0, wr, ad, {24'h0, wd}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
    end while (rsp.pready !== 1'b1 && t < 20);
    if (t == 20) begin
      n_errors++;
      complete_run();
    end
    req <= '0;
    @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      complete_run();
    end
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0) begin
      chk({rsp.pslverr, rsp.prdata}, expq.pop_front(), "read");
    end
  end
////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    d = 8'($urandom(32'h4520));
    repeat (12) @(posedge mclk);
    vl  <= 7'($urandom);
    vr  <= 7'($urandom);
    rst <= 1'b0;
    cyc_n(40);
    cv = (vl > vr) ? vl : vr;
    apb(R, A_CTL, 8'h00, 33'h0);
    apb(R, A_TS, 8'h00, 33'h9);
    apb(R, A_SPK, 8'h00, 33'h81);
    apb(R, 12'h100, 8'h00, 33'h1_0000_0000);
    apb(W, A_ST, 8'h7F, 33'h0);
    apb(R, A_ST, 8'h00, {26'h0, cv});
    d = 8'($urandom);
    apb(W, A_CTL, d, 33'h0);
    apb(R, A_CTL, 8'h00, {25'h0, d});
    for (int i = 0; i < 16; i++) begin
      apb(W, A_TS, 8'(i << 2), 33'h0);
      cyc_n(3);
      chk(33'(ltrip), 33'(32'h6E + 32'h0F * (i % 4)), "low");
      chk(33'(htrip), 33'(32'h6E + 32'h0F * (i % 4) + 32'h0F * (i / 4 + 1)),
          "hi");
    end
    heat <= 2'h3;
    cyc_n(4);
    apb(R, A_TS, 8'h00, 33'hFC);
    d = 8'h80 | 8'($urandom % 16);
    apb(W, A_SPK, d, 33'h0);
    apb(W, A_CTL, 8'h03, 33'h0);
    cyc_n(576);
    chk({mute, pwd, btl, vol}, 33'h300, "pwd");
    apb(R, A_ST, 8'h00, 33'h80);
    heat <= 2'h1;
    cyc_n(48);
    chk({mute, pwd}, 33'h0, "unmute");
    apb(R, A_ST, 8'h00, 33'h0);
    heat <= 2'h0;
    cyc_n(2100);
    apb(R, A_ST, 8'h00, {26'h0, cv});
    chk(33'(vol), 33'(cv), "vol");
    apb(W, A_SPK, 8'hC0 | 8'($urandom % 64), 33'h0);
    heat <= 2'h1;
    cyc_n(40);
    apb(R, A_ST, 8'h00, {26'h0, cv});
    heat <= 2'h3;
    cyc_n(20);
    apb(R, A_ST, 8'h00, 33'h0);
    cyc_n(40);
    apb(R, A_ST, 8'h00, 33'h80);
    heat <= 2'h1;
    cyc_n(24);
    apb(R, A_ST, 8'h00, {26'h0, cv});
    chk(33'(vol), 33'(cv), "hard vol");
    apb(W, A_SPK, 8'h03, 33'h0);
    heat <= 2'h3;
    cyc_n(160);
    chk({mute, pwd, btl}, 33'h5, "no pwd");
    apb(R, A_ST, 8'h00, 33'h0);
    shrt <= 1'b1;
    @(posedge mclk);
    shrt <= 1'b0;
    cyc_n(3);
    chk(33'(btl), 33'h0, "short off");
    cyc_n(10);
    chk(33'(btl), 33'h1, "retry on");
    complete_run();
  end
endmodule
bind stv_top stv_top_props stv_top_props_i (.mclk(mclk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .short_det(short_det),
  .spk_mute(spk_mute), .spk_powerdown(spk_powerdown),
  .btl_enable(btl_enable), .low_trip_degc(low_trip_degc),
  .high_trip_degc(high_trip_degc));
